/* File: logic/input_overcurrent_fault_protect.sv */
// Function
// - Fault when measured input current exceeds the programmed limit.
// - Limit bits 15:11 read-only, return exponent from exponent register.
// - Limit bits 10:8 read/write, upper mantissa bits; limit is Y times 2^N.
// - Limit bits 7:0 read/write, lower mantissa byte.
// - Response bits 7:6 select action; code 00 ignores the fault.
// - Code 01 keeps running for shutdown delay, then applies retry behaviour.
// - Code 10 disables output at once, then retries per retry count.
// - Response bits 5:3 are a read/write retry count.
// - Fault persisting after all retries latches the output off.
// - Latched fault clears only on device reset.
// - Restart attempts are spaced by the interval from bits 2:0.
// - Delay code selects shutdown delay 10 to 1280 ms.
// - Delay code selects restart interval 252 to 2604 ms.
`timescale 1ns/1ps
`default_nettype none
module input_overcurrent_fault_protect #(
   parameter int MS_CYCLES = iin_oc_pkg::MS_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic [4:0] exponent_n,
   input wire logic [10:0] iin_mantissa,
   output logic output_enable,
   output logic fault_present,
   output logic fault_latched
);
   logic [iin_oc_pkg::MANT_W-1:0] limit_r;
   logic [7:0] action_r;
   logic [15:0] rdata_r;
   logic fault_r;
   logic oe_r;
   logic latched_r;
   logic [31:0] div_r;
   logic [iin_oc_pkg::MS_W-1:0] ms_r;
   logic [2:0] tries_r;
   logic [2:0] tries_nxt;
   iin_oc_pkg::prot_state_t st_r;
   iin_oc_pkg::prot_state_t st_nxt;
   logic ms_clear;

   wire limit_sel = reg_addr == iin_oc_pkg::LIMIT_ADDR;
   wire action_sel = reg_addr == iin_oc_pkg::ACTION_ADDR;
   wire [1:0] resp = action_r[iin_oc_pkg::RESP_MSB:iin_oc_pkg::RESP_LSB];
   wire [2:0] retry = action_r[iin_oc_pkg::RETRY_MSB:iin_oc_pkg::RETRY_LSB];
   wire [2:0] dcode = action_r[iin_oc_pkg::DELAY_MSB:iin_oc_pkg::DELAY_LSB];
   wire [11:0] shut_ms = iin_oc_pkg::SHUT_MS[dcode];
   wire [11:0] restart_ms = iin_oc_pkg::RESTART_MS[dcode];
   wire ms_tick = div_r == 32'(MS_CYCLES - 1);
   wire shut_done = ms_tick && (ms_r + 12'h001 >= shut_ms);
   wire restart_done = ms_tick && (ms_r + 12'h001 >= restart_ms);
   // Unlimited code never exhausts the attempt budget
   wire may_retry = (retry == iin_oc_pkg::RETRY_FOREVER) || (tries_r < retry);
   // Measured current shares the limit's exponent, so mantissas compare directly
   wire over = iin_mantissa > limit_r;
   wire [15:0] limit_read = {exponent_n, limit_r};
   wire [15:0] read_mux = limit_sel ? limit_read :
                          action_sel ? {8'h00, action_r} : 16'h0000;

   always_ff @(posedge clock) begin
      if (reset) begin
         limit_r <= iin_oc_pkg::LIMIT_RESET;
         action_r <= iin_oc_pkg::ACTION_RESET;
         rdata_r <= 16'h0000;
      end else begin
         if (reg_write && limit_sel) begin
            limit_r <= reg_wdata[iin_oc_pkg::MANT_MSB:0];
         end
         if (reg_write && action_sel) begin
            action_r <= reg_wdata[7:0];
         end
         if (reg_read) begin
            rdata_r <= read_mux;
         end
      end
   end

   always_comb begin
      st_nxt = st_r;
      tries_nxt = tries_r;
      ms_clear = 1'b0;
      unique case (st_r)
         iin_oc_pkg::RUN: begin
            if (fault_r) begin
               ms_clear = 1'b1;
               unique case (resp)
                  iin_oc_pkg::RESP_IGNORE: st_nxt = iin_oc_pkg::RUN;
                  iin_oc_pkg::RESP_RIDE: st_nxt = iin_oc_pkg::RIDE;
                  iin_oc_pkg::RESP_RETRY: begin
                     st_nxt = may_retry ? iin_oc_pkg::OFF_WAIT : iin_oc_pkg::LATCHED;
                     tries_nxt = may_retry ? tries_r + 3'h1 : tries_r;
                  end
                  iin_oc_pkg::RESP_HOLD: st_nxt = iin_oc_pkg::HOLD;
               endcase
            end else if (shut_done) begin
               // A clean stretch as long as the shutdown delay refills the budget
               ms_clear = 1'b1;
               tries_nxt = 3'h0;
            end
         end
         iin_oc_pkg::RIDE: begin
            if (!fault_r) begin
               st_nxt = iin_oc_pkg::RUN;
               ms_clear = 1'b1;
            end else if (shut_done) begin
               st_nxt = may_retry ? iin_oc_pkg::OFF_WAIT : iin_oc_pkg::LATCHED;
               tries_nxt = may_retry ? tries_r + 3'h1 : tries_r;
               ms_clear = 1'b1;
            end
         end
         iin_oc_pkg::OFF_WAIT: begin
            if (restart_done) begin
               st_nxt = iin_oc_pkg::RUN;
               ms_clear = 1'b1;
            end
         end
         iin_oc_pkg::HOLD: begin
            if (!fault_r) begin
               st_nxt = iin_oc_pkg::RUN;
               ms_clear = 1'b1;
            end
         end
         iin_oc_pkg::LATCHED: st_nxt = iin_oc_pkg::LATCHED;
         default: st_nxt = iin_oc_pkg::LATCHED;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_r <= iin_oc_pkg::RUN;
         tries_r <= 3'h0;
         fault_r <= 1'b0;
         oe_r <= 1'b0;
         latched_r <= 1'b0;
         div_r <= 32'h00000000;
         ms_r <= 12'h000;
      end else begin
         st_r <= st_nxt;
         tries_r <= tries_nxt;
         fault_r <= over;
         oe_r <= (st_nxt == iin_oc_pkg::RUN) || (st_nxt == iin_oc_pkg::RIDE);
         latched_r <= st_nxt == iin_oc_pkg::LATCHED;
         div_r <= (ms_clear || ms_tick) ? 32'h00000000 : div_r + 32'h00000001;
         ms_r <= ms_clear ? 12'h000 : (ms_tick ? ms_r + 12'h001 : ms_r);
      end
   end

   assign reg_rdata = rdata_r;
   assign output_enable = oe_r;
   assign fault_present = fault_r;
   assign fault_latched = latched_r;

   sequence seq_fault_in_run(logic [1:0] code);
      st_r == iin_oc_pkg::RUN && fault_r && resp == code;
   endsequence

   chk_ignore_code: assert property (@(posedge clock) disable iff (reset)
      seq_fault_in_run(iin_oc_pkg::RESP_IGNORE) |=> st_r == iin_oc_pkg::RUN && oe_r)
      else $error("ignore code changed state");
   chk_ride_on: assert property (@(posedge clock) disable iff (reset)
      seq_fault_in_run(iin_oc_pkg::RESP_RIDE) |=> oe_r && st_r == iin_oc_pkg::RIDE)
      else $error("ride through did not keep output on");
   chk_immediate_off: assert property (@(posedge clock) disable iff (reset)
      seq_fault_in_run(iin_oc_pkg::RESP_RETRY) |=> !oe_r)
      else $error("retry code did not shut down at once");
   chk_hold_off: assert property (@(posedge clock) disable iff (reset)
      st_r == iin_oc_pkg::HOLD |-> !oe_r)
      else $error("output on while holding");
   chk_hold_resume: assert property (@(posedge clock) disable iff (reset)
      st_r == iin_oc_pkg::HOLD && !fault_r |=> oe_r && st_r == iin_oc_pkg::RUN)
      else $error("hold did not resume");
   chk_latch_stays: assert property (@(posedge clock) disable iff (reset)
      st_r == iin_oc_pkg::LATCHED |=> st_r == iin_oc_pkg::LATCHED && !oe_r && fault_latched)
      else $error("latched fault released");
   chk_retry_bound: assert property (@(posedge clock) disable iff (reset)
      $rose(st_r == iin_oc_pkg::OFF_WAIT) |-> retry == iin_oc_pkg::RETRY_FOREVER
         || tries_r <= retry)
      else $error("retry budget exceeded");
   chk_restart_gap: assert property (@(posedge clock) disable iff (reset)
      st_r == iin_oc_pkg::OFF_WAIT && $past(st_r) == iin_oc_pkg::OFF_WAIT
         && st_nxt == iin_oc_pkg::RUN |-> ms_r + 12'h001 >= restart_ms)
      else $error("restart came early");
   chk_exp_read: assert property (@(posedge clock) disable iff (reset)
      reg_read && limit_sel |=> reg_rdata[15:11] == $past(exponent_n))
      else $error("exponent not returned");
   chk_mant_write: assert property (@(posedge clock) disable iff (reset)
      reg_write && limit_sel |=> limit_r == $past(reg_wdata[10:0]))
      else $error("mantissa not stored");
   chk_fault_detect: assert property (@(posedge clock) disable iff (reset)
      iin_mantissa > limit_r |=> fault_present)
      else $error("overcurrent missed");
endmodule : input_overcurrent_fault_protect
`default_nettype wire

/* File: logic/iin_oc_pkg.sv */
`default_nettype none
package iin_oc_pkg;
   // Register command codes
   localparam logic [7:0] LIMIT_ADDR = 8'h5B;
   localparam logic [7:0] ACTION_ADDR = 8'h5C;
   // Limit register fields
   localparam int EXP_MSB = 15;
   localparam int EXP_LSB = 11;
   localparam int MANT_MSB = 10;
   localparam int MANT_W = 11;
   localparam int EXP_W = 5;
   // Action register fields
   localparam int RESP_MSB = 7;
   localparam int RESP_LSB = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DELAY_MSB = 2;
   localparam int DELAY_LSB = 0;
   // Reset values
   localparam logic [10:0] LIMIT_RESET = 11'h7FF;
   localparam logic [7:0] ACTION_RESET = 8'h80;
   // Response codes
   localparam logic [1:0] RESP_IGNORE = 2'h0;
   localparam logic [1:0] RESP_RIDE = 2'h1;
   localparam logic [1:0] RESP_RETRY = 2'h2;
   localparam logic [1:0] RESP_HOLD = 2'h3;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // Timing: clock rate and millisecond base
   localparam int CLOCK_HZ = 10000000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLOCK_HZ / MS_PER_S;
   localparam int MS_W = 12;
   // Shutdown delay in ms, index = delay code
   localparam logic [7:0][11:0] SHUT_MS = {
      12'h500, 12'h280, 12'h140, 12'h0A0, 12'h050, 12'h028, 12'h014, 12'h00A};
   // Restart interval in ms, index = delay code
   localparam logic [7:0][11:0] RESTART_MS = {
      12'hA2C, 12'h8DC, 12'h78C, 12'h63C, 12'h4EC, 12'h39C, 12'h22E, 12'h0FC};
   typedef enum logic [2:0] {RUN, RIDE, OFF_WAIT, HOLD, LATCHED} prot_state_t;
endpackage : iin_oc_pkg
`default_nettype wire

/* File: dv/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clock,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // An idle edge ends each task, so a strobe is never set twice in one step
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
      d = reg_rdata;
   endtask : rd
endmodule : host_model
`default_nettype wire

/* File: dv/test_input_overcurrent_fault_protect.sv */
`timescale 1ns/1ps
`default_nettype none
module test_input_overcurrent_fault_protect;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [4:0] exponent_n = 5'h0A;
   logic [10:0] iin_mantissa = 11'h000;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic reg_write, reg_read, output_enable, fault_present, fault_latched;
   int fails = 0;
   int checked = 0;
   // Short ms tick keeps the 252 ms restart wait near 1000 cycles
   input_overcurrent_fault_protect #(.MS_CYCLES(4)) input_overcurrent_fault_protect_inst (
      .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .exponent_n(exponent_n), .iin_mantissa(iin_mantissa), .output_enable(output_enable),
      .fault_present(fault_present), .fault_latched(fault_latched));
   host_model host_model_inst (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   initial begin
      forever #50 clock = ~clock;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic do_reset();
      reset <= 1'b1;
      cyc(12);
      reset <= 1'b0;
      cyc(2);
   endtask : do_reset
   task automatic end_of_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   task automatic t_regs();
      host_model_inst.wr(iin_oc_pkg::LIMIT_ADDR, 16'hF123);
      host_model_inst.rd(iin_oc_pkg::LIMIT_ADDR, d);
      check("limit", d, {5'h0A, 11'h123});
      host_model_inst.wr(iin_oc_pkg::ACTION_ADDR, 16'h005A);
      host_model_inst.rd(iin_oc_pkg::ACTION_ADDR, d);
      check("action", d, 16'h005A);
      host_model_inst.rd(8'h00, d);
      check("unmapped", d, 16'h0000);
      $display("test regs done");
   endtask : t_regs
   task automatic t_ignore();
      host_model_inst.wr(iin_oc_pkg::ACTION_ADDR, 16'h0000);
      iin_mantissa <= 11'h124;
      cyc(3);
      check("ign_fault", fault_present, 1'b1);
      cyc(60);
      check("ign_oe", output_enable, 1'b1);
      iin_mantissa <= 11'h000;
      cyc(3);
      $display("test ignore done");
   endtask : t_ignore
   task automatic t_retry();
      host_model_inst.wr(iin_oc_pkg::ACTION_ADDR, 16'h0088);
      iin_mantissa <= 11'h124;
      cyc(3);
      check("ret_off", output_enable, 1'b0);
      cyc(995);
      check("ret_wait", output_enable, 1'b0);
      iin_mantissa <= 11'h123;
      cyc(30);
      check("ret_on", output_enable, 1'b1);
      check("ret_equal", fault_present, 1'b0);
      $display("test retry done");
   endtask : t_retry
   task automatic t_ride();
      host_model_inst.wr(iin_oc_pkg::ACTION_ADDR, 16'h0040);
      iin_mantissa <= 11'h124;
      cyc(30);
      check("ride_on", output_enable, 1'b1);
      cyc(25);
      check("ride_off", output_enable, 1'b0);
      check("ride_latch", fault_latched, 1'b1);
      iin_mantissa <= 11'h000;
      cyc(1100);
      check("latch_hold", output_enable, 1'b0);
      do_reset();
      check("latch_clear", fault_latched, 1'b0);
      check("reset_on", output_enable, 1'b1);
      $display("test ride done");
   endtask : t_ride
   task automatic t_hold();
      host_model_inst.wr(iin_oc_pkg::LIMIT_ADDR, 16'h0123);
      host_model_inst.wr(iin_oc_pkg::ACTION_ADDR, 16'h00C0);
      iin_mantissa <= 11'h124;
      cyc(3);
      check("hold_off", output_enable, 1'b0);
      cyc(2000);
      check("hold_stay", output_enable, 1'b0);
      iin_mantissa <= 11'h000;
      cyc(3);
      check("hold_on", output_enable, 1'b1);
      $display("test hold done");
   endtask : t_hold
   // Unlimited retries: a held fault must keep cycling, never latch
   task automatic t_forever();
      host_model_inst.wr(iin_oc_pkg::ACTION_ADDR, 16'h00B8);
      iin_mantissa <= 11'h124;
      cyc(1100);
      check("fev_off", output_enable, 1'b0);
      check("fev_latch", fault_latched, 1'b0);
      iin_mantissa <= 11'h000;
      cyc(1000);
      check("fev_on", output_enable, 1'b1);
      $display("test forever done");
   endtask : t_forever
   initial begin
      cyc(9000);
      fails++;
      end_of_test();
   end
   initial begin
      do_reset();
      t_regs();
      t_ignore();
      t_retry();
      t_ride();
      t_hold();
      t_forever();
      end_of_test();
   end
endmodule : test_input_overcurrent_fault_protect
`default_nettype wire
